// ===== logic/pdsc_params.svh
// Summary of operation
// - Halt with standby select enters standby
// - Standby drives upper low, lower high
// - Wake starts settle timer, overflow resumes
// - Interrupt wake loads event code register
// - Wakes accepted despite mask-all flag
// - Encoded level wakes only with calendar clock
// - GPIO wakes only with calendar clock
// - Reset pin ends standby, bus clock runs
// - Stop bits gate peripheral clocks
// - Gated modules hold pins and registers
// - Clock stop bits gate bridge, timers, detection
// - Module stop bits gate seven modules
// - Clear module stop by 0, clock stop by clear word
// - Power-on reset keeps stop settings
// - Standby pin low enters hardware standby
// - Hardware standby ignores interrupts, floats outputs unless entered from standby
// - High-impedance select drives power-state enable in hardware standby only
// - Pin in standby stays stopped; settling restarts briefly
// - Only power-on reset ends hardware standby
// - State code HH reset, LH standby, LL normal
`ifndef PDSC_PARAMS_SVH
`define PDSC_PARAMS_SVH
`define PDSC_OFF_CTRL 8'h00
`define PDSC_OFF_PCTL2 8'h04
`define PDSC_OFF_CLKSTOP 8'h08
`define PDSC_OFF_CLKCLR 8'h0c
`define PDSC_OFF_SETTLE 8'h10
`define PDSC_OFF_STATUS 8'h14
`define PDSC_OFF_EVENT 8'h18
`define PDSC_BIT_STBYSEL 7
`define PDSC_BIT_STATUS_HIZ_SELECT 0
`define PDSC_MSTP_TIMER 2
`define PDSC_MSTP_CAL 1
`define PDSC_SETTLE_RST 16'h0100
`define PDSC_BRIEF_CYC 4'h2
`define PDSC_EVT_NMI 12'h1c0
`define PDSC_EVT_IRL 12'h200
`define PDSC_EVT_CAL 12'h480
`define PDSC_EVT_GPIO 12'h700
`endif

// ===== logic/pdsc_pkg.sv
package pdsc_pkg;
	typedef enum logic [2:0] {
		PDSC_RESET,
		PDSC_NORMAL,
		PDSC_STANDBY,
		PDSC_SETTLE,
		PDSC_BRIEF,
		PDSC_HWSTBY
	} pdsc_state_e;
	typedef struct packed {
		logic upper;
		logic lower;
		logic oe;
	} pdsc_pstate_s;
	typedef struct packed {
		logic cpu;
		logic periph;
		logic busOut;
	} pdsc_clken_s;
endpackage

// ===== logic/pdsc_top.sv
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`include "pdsc_params.svh"
module pdsc_top
	import pdsc_pkg::*;
#(
	parameter int MOD_N = 7,
	parameter int CSTP_N = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic resetPinN,
	input wire logic manualResetPinN,
	input wire logic hwStandbyPinN,
	input wire logic haltExec,
	input wire logic nmiReq,
	input wire logic [3:0] encodedIrqLevel,
	input wire logic [3:0] gpioWakeLevel,
	input wire logic calWakeReq,
	input wire logic calClockRunning,
	input wire logic [3:0] priorityMaskLevel,
	output pdsc_pstate_s powerState,
	output pdsc_clken_s clockEnable,
	output logic pinsOe,
	output logic pullUpEn,
	output logic [MOD_N-1:0] moduleClockEn,
	output logic pciBridgeClockEn,
	output logic timer34ClockEn,
	output logic pciTimerIrqDetectEn,
	output logic timerStartInit,
	output logic wakeIrq,
	output logic [11:0] eventCode
);

	pdsc_state_e state;
	pdsc_state_e next_state;
	logic standbySelect;
	logic statusHizSelect;
	logic [MOD_N-1:0] moduleStop;
	logic [CSTP_N-1:0] clockStop;
	logic [15:0] settleReload;
	logic [15:0] settleCount;
	logic [3:0] briefCount;
	logic [11:0] pendingCode;
	logic [11:0] next_code;
	logic hwFromStandby;
	logic dpWrite;
	logic [7:0] dpAddr;
	logic wrEn;
	logic wakeAny;
	logic irlWake;
	logic gpioWake;
	logic running;
	logic [MOD_N-1:0] next_modEn;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign wrEn = dpWrite;

	// Address phase capture
	always_ff @(posedge clk) begin
		if (rst) begin
			dpWrite <= 1'b0;
			dpAddr <= 8'h00;
		end else if (ce && hready) begin
			dpWrite <= hsel && htrans[1] && hwrite;
			dpAddr <= haddr[7:0];
		end
	end

	// Read data for the next data phase
	always_ff @(posedge clk) begin
		if (rst) begin
			hrdata <= 32'h00000000;
		end else if (ce && hready) begin
			hrdata <= 32'h00000000;
			if (hsel && htrans[1] && !hwrite) begin
				if (haddr[7:0] == `PDSC_OFF_CTRL) begin
					hrdata[`PDSC_BIT_STBYSEL] <= standbySelect;
					hrdata[MOD_N-1:0] <= moduleStop;
				end else if (haddr[7:0] == `PDSC_OFF_PCTL2) begin
					hrdata[`PDSC_BIT_STATUS_HIZ_SELECT] <= statusHizSelect;
				end else if (haddr[7:0] == `PDSC_OFF_CLKSTOP) begin
					hrdata[CSTP_N-1:0] <= clockStop;
				end else if (haddr[7:0] == `PDSC_OFF_SETTLE) begin
					hrdata[15:0] <= settleReload;
				end else if (haddr[7:0] == `PDSC_OFF_STATUS) begin
					hrdata[2:0] <= 3'(state);
					hrdata[3] <= powerState.upper;
					hrdata[4] <= powerState.lower;
					hrdata[31:16] <= settleCount;
				end else if (haddr[7:0] == `PDSC_OFF_EVENT) begin
					hrdata[11:0] <= eventCode;
				end
			end
		end
	end

	// Control registers; pin resets leave the stop bits alone
	always_ff @(posedge clk) begin
		if (rst) begin
			standbySelect <= 1'b0;
			statusHizSelect <= 1'b0;
			settleReload <= `PDSC_SETTLE_RST;
		end else if (ce && wrEn) begin
			if (dpAddr == `PDSC_OFF_CTRL) begin
				standbySelect <= hwdata[`PDSC_BIT_STBYSEL];
			end else if (dpAddr == `PDSC_OFF_PCTL2) begin
				statusHizSelect <= hwdata[`PDSC_BIT_STATUS_HIZ_SELECT];
			end else if (dpAddr == `PDSC_OFF_SETTLE) begin
				settleReload <= hwdata[15:0];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			moduleStop <= '0;
		end else if (ce && wrEn && dpAddr == `PDSC_OFF_CTRL) begin
			moduleStop <= hwdata[MOD_N-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			clockStop <= '0;
		end else if (ce && wrEn) begin
			if (dpAddr == `PDSC_OFF_CLKSTOP) begin
				clockStop <= clockStop | hwdata[CSTP_N-1:0];
			end else if (dpAddr == `PDSC_OFF_CLKCLR) begin
				clockStop <= clockStop & ~hwdata[CSTP_N-1:0];
			end
		end
	end

	// Wake sources; mask-all flag is deliberately not consulted
	assign irlWake = calClockRunning && (encodedIrqLevel > priorityMaskLevel);
	assign gpioWake = calClockRunning && (gpioWakeLevel > priorityMaskLevel);
	assign wakeAny = nmiReq || irlWake || gpioWake || calWakeReq;

	always_comb begin
		if (nmiReq) begin
			next_code = `PDSC_EVT_NMI;
		end else if (irlWake) begin
			next_code = `PDSC_EVT_IRL + {3'h0, ~encodedIrqLevel, 5'h00};
		end else if (gpioWake) begin
			next_code = `PDSC_EVT_GPIO;
		end else begin
			next_code = `PDSC_EVT_CAL;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			PDSC_RESET: begin
				if (resetPinN && manualResetPinN) begin
					next_state = PDSC_NORMAL;
				end
			end
			PDSC_NORMAL: begin
				if (!hwStandbyPinN) begin
					next_state = PDSC_HWSTBY;
				end else if (haltExec && standbySelect) begin
					next_state = PDSC_STANDBY;
				end
			end
			PDSC_STANDBY: begin
				if (!hwStandbyPinN) begin
					next_state = PDSC_HWSTBY;
				end else if (wakeAny) begin
					next_state = PDSC_SETTLE;
				end
			end
			PDSC_SETTLE: begin
				if (!hwStandbyPinN) begin
					next_state = PDSC_BRIEF;
				end else if (settleCount == 16'h0000) begin
					next_state = PDSC_NORMAL;
				end
			end
			PDSC_BRIEF: begin
				if (briefCount == 4'h1) begin
					next_state = PDSC_HWSTBY;
				end
			end
			PDSC_HWSTBY: begin
				next_state = PDSC_HWSTBY;
			end
			default: begin
				next_state = PDSC_RESET;
			end
		endcase
		if (state == PDSC_HWSTBY) begin
			if (!resetPinN && hwStandbyPinN) begin
				next_state = PDSC_RESET;
			end
		end else if (!resetPinN || !manualResetPinN) begin
			next_state = PDSC_RESET;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state <= PDSC_RESET;
		end else if (ce) begin
			state <= next_state;
		end
	end

	// Settling timer
	always_ff @(posedge clk) begin
		if (rst) begin
			settleCount <= 16'h0000;
		end else if (ce) begin
			if (state == PDSC_STANDBY && next_state == PDSC_SETTLE) begin
				settleCount <= settleReload;
			end else if (state == PDSC_SETTLE && settleCount != 16'h0000) begin
				settleCount <= settleCount - 16'h0001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			briefCount <= 4'h0;
		end else if (ce) begin
			if (next_state == PDSC_BRIEF && state != PDSC_BRIEF) begin
				briefCount <= `PDSC_BRIEF_CYC;
			end else if (state == PDSC_BRIEF) begin
				briefCount <= briefCount - 4'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			hwFromStandby <= 1'b0;
		end else if (ce && next_state == PDSC_HWSTBY && state != PDSC_HWSTBY) begin
			hwFromStandby <= (state == PDSC_STANDBY);
		end
	end

	// Event code and wake pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			pendingCode <= 12'h000;
		end else if (ce && state == PDSC_STANDBY && next_state == PDSC_SETTLE) begin
			pendingCode <= next_code;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			eventCode <= 12'h000;
			wakeIrq <= 1'b0;
		end else if (ce) begin
			wakeIrq <= 1'b0;
			if (state == PDSC_SETTLE && next_state == PDSC_NORMAL) begin
				eventCode <= pendingCode;
				wakeIrq <= 1'b1;
			end
		end
	end

	// Power-state code and pin drive
	always_ff @(posedge clk) begin
		if (rst) begin
			powerState <= '{upper: 1'b1, lower: 1'b1, oe: 1'b1};
		end else if (ce) begin
			case (next_state)
				PDSC_RESET: begin
					powerState <= '{upper: 1'b1, lower: 1'b1, oe: 1'b1};
				end
				PDSC_STANDBY, PDSC_SETTLE: begin
					powerState <= '{upper: 1'b0, lower: 1'b1, oe: 1'b1};
				end
				PDSC_HWSTBY: begin
					powerState <= '{upper: 1'b0, lower: 1'b1, oe: !statusHizSelect};
				end
				default: begin
					powerState <= '{upper: 1'b0, lower: 1'b0, oe: 1'b1};
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pinsOe <= 1'b1;
			pullUpEn <= 1'b1;
		end else if (ce) begin
			// Entry cycle looks at the live state, later cycles at the stored origin
			pinsOe <= (next_state != PDSC_HWSTBY)
				|| ((state == PDSC_HWSTBY) ? hwFromStandby : (state == PDSC_STANDBY));
			pullUpEn <= (next_state != PDSC_HWSTBY);
		end
	end

	// Clock enables
	assign running = (next_state == PDSC_NORMAL) || (next_state == PDSC_BRIEF)
		|| (next_state == PDSC_RESET);

	always_comb begin
		next_modEn = '0;
		for (int k = 0; k < MOD_N; k++) begin
			next_modEn[k] = running && !moduleStop[k];
		end
		if (next_state != PDSC_RESET && !running) begin
			next_modEn[`PDSC_MSTP_CAL] = !moduleStop[`PDSC_MSTP_CAL];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			clockEnable <= '{cpu: 1'b1, periph: 1'b1, busOut: 1'b1};
			moduleClockEn <= '0;
		end else if (ce) begin
			clockEnable <= '{cpu: running, periph: running, busOut: running};
			moduleClockEn <= next_modEn;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pciBridgeClockEn <= 1'b0;
			timer34ClockEn <= 1'b0;
			pciTimerIrqDetectEn <= 1'b0;
		end else if (ce) begin
			pciBridgeClockEn <= running && !clockStop[2];
			timer34ClockEn <= running && !clockStop[1];
			pciTimerIrqDetectEn <= running && !clockStop[0];
		end
	end

	// Timer start word cleared on gating or standby entry
	always_ff @(posedge clk) begin
		if (rst) begin
			timerStartInit <= 1'b0;
		end else if (ce) begin
			timerStartInit <= (wrEn && dpAddr == `PDSC_OFF_CTRL
				&& hwdata[`PDSC_MSTP_TIMER] && !moduleStop[`PDSC_MSTP_TIMER])
				|| (state == PDSC_NORMAL && next_state == PDSC_STANDBY);
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst || !ce);

	sequence s_briefRun;
		(state == PDSC_BRIEF) [*2] ##1 (state == PDSC_HWSTBY);
	endsequence

	sequence s_quiet;
		resetPinN && manualResetPinN && hwStandbyPinN;
	endsequence

	property p_standbyCode;
		(state == PDSC_STANDBY) |-> !powerState.upper && powerState.lower;
	endproperty
	a_standbyCode: assert property (p_standbyCode) else $error("standby code wrong");

	property p_resetCode;
		(state == PDSC_RESET) |-> powerState.upper && powerState.lower;
	endproperty
	a_resetCode: assert property (p_resetCode) else $error("reset code wrong");

	property p_wake;
		(((state == PDSC_STANDBY) && wakeAny) and s_quiet) |=> (state == PDSC_SETTLE)
			&& (settleCount == $past(settleReload));
	endproperty
	a_wake: assert property (p_wake) else $error("wake did not start timer");

	property p_settleDone;
		(((state == PDSC_SETTLE) && (settleCount == 16'h0000)) and s_quiet)
			|=> (state == PDSC_NORMAL) && wakeIrq && (eventCode == pendingCode)
			&& !powerState.upper && !powerState.lower;
	endproperty
	a_settleDone: assert property (p_settleDone) else $error("settle exit wrong");

	property p_irlGate;
		(((state == PDSC_STANDBY) && !calClockRunning && !nmiReq && !calWakeReq)
			and s_quiet) |=> (state == PDSC_STANDBY);
	endproperty
	a_irlGate: assert property (p_irlGate) else $error("level wake without clock");

	property p_clockStopHold;
		!(wrEn && dpAddr == `PDSC_OFF_CLKCLR) |=> ((~clockStop & $past(clockStop)) == '0);
	endproperty
	a_clockStopHold: assert property (p_clockStopHold) else $error("clock stop lost");

	property p_pinReset;
		!resetPinN && !wrEn |=> (moduleStop == $past(moduleStop));
	endproperty
	a_pinReset: assert property (p_pinReset) else $error("stop bits reset");

	property p_hwHold;
		(state == PDSC_HWSTBY) && resetPinN |=> (state == PDSC_HWSTBY) && !pullUpEn;
	endproperty
	a_hwHold: assert property (p_hwHold) else $error("hardware standby left");

	property p_hwOe;
		(state == PDSC_HWSTBY) |-> (powerState.oe == !$past(statusHizSelect));
	endproperty
	a_hwOe: assert property (p_hwOe) else $error("status drive wrong");

	property p_brief;
		(state == PDSC_SETTLE) && !hwStandbyPinN && resetPinN && manualResetPinN
			|=> s_briefRun;
	endproperty
	a_brief: assert property (p_brief) else $error("brief restart wrong");

	property p_gate;
		// Enables are registered, so they trail the stop bits by one cycle
		((moduleClockEn & $past(moduleStop)) == '0)
			&& !(pciBridgeClockEn && $past(clockStop[2]));
	endproperty
	a_gate: assert property (p_gate) else $error("gated clock running");

endmodule

// ===== tb/pdsc_sup.sv
`timescale 1ns/100ps
module pdsc_sup
	import pdsc_pkg::*;
(
	input wire logic clk,
	input wire logic reqWake,
	input wire logic reqHw,
	input wire logic reqPor,
	input wire logic reqMr,
	input pdsc_pstate_s powerState,
	output logic resetPinN = 1'h1,
	output logic manualResetPinN = 1'h1,
	output logic hwStandbyPinN = 1'h1,
	output logic nmiReq = 1'h0,
	output logic clockOn = 1'h1,
	output logic porBusy = 1'h0
);
	logic [3:0] porCnt = 4'h0;
	always @(posedge clk) begin
		manualResetPinN <= !reqMr;
		if (!powerState.upper && powerState.lower && !reqWake)
			clockOn <= 1'h0;
		if (reqWake) begin
			clockOn <= 1'h1;
			nmiReq <= clockOn;
		end else
			nmiReq <= 1'h0;
		if (reqPor) begin
			resetPinN <= 1'h0;
			porBusy <= 1'h1;
			porCnt <= 4'h0;
		end else if (porBusy) begin
			porCnt <= porCnt + 4'h1;
			if (porCnt == 4'h1)
				hwStandbyPinN <= 1'h1;
			if (porCnt == 4'h9) begin
				resetPinN <= 1'h1;
				porBusy <= 1'h0;
			end
		end
		if (reqHw)
			hwStandbyPinN <= 1'h0;
	end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/100ps
`include "pdsc_params.svh"
module testbench
	import pdsc_pkg::*;
();
	logic clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, haltExec = 1'h0;
	logic calWake = 1'h0, calRun = 1'h0, reqWake = 1'h0, reqHw = 1'h0, reqPor = 1'h0;
	logic reqMr = 1'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic [1:0] htrans = 2'h0;
	logic [3:0] irl = 4'h0, gpio = 4'h0, mask = 4'h0, lv, mk;
	logic [6:0] m, modEn;
	logic [11:0] eventCode;
	logic hreadyout, resetPinN, manualResetPinN, hwStandbyPinN, nmiReq, pinsOe, pullUpEn;
	logic pci, t34, det, wakeIrq, tsi;
	pdsc_pstate_s powerState;
	pdsc_clken_s clockEnable;
	int mismatches = 0, samplesChecked = 0, cyc = 0, i, s, n, r;
	pdsc_top u_dut (.clk(clk), .rst(rst), .ce(1'h1), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .resetPinN(resetPinN),
		.manualResetPinN(manualResetPinN), .hwStandbyPinN(hwStandbyPinN),
		.haltExec(haltExec), .nmiReq(nmiReq), .encodedIrqLevel(irl), .gpioWakeLevel(gpio),
		.calWakeReq(calWake), .calClockRunning(calRun), .priorityMaskLevel(mask),
		.powerState(powerState), .clockEnable(clockEnable), .pinsOe(pinsOe),
		.pullUpEn(pullUpEn), .moduleClockEn(modEn), .pciBridgeClockEn(pci),
		.timer34ClockEn(t34), .pciTimerIrqDetectEn(det), .timerStartInit(tsi),
		.wakeIrq(wakeIrq), .eventCode(eventCode));
	pdsc_sup u_sup (.clk(clk), .reqWake(reqWake), .reqHw(reqHw), .reqPor(reqPor),
		.reqMr(reqMr), .powerState(powerState), .resetPinN(resetPinN),
		.manualResetPinN(manualResetPinN), .hwStandbyPinN(hwStandbyPinN),
		.nmiReq(nmiReq), .clockOn(), .porBusy());
	initial forever #50 clk = ~clk;
	task automatic print_verdict();
		$display("checked %0d mismatches %0d", samplesChecked, mismatches);
		if (mismatches == 0 && samplesChecked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// Single AHB transfer; waits on hready in both phases
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int w;
		w = 0;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		hsel <= 1'h1;
		do begin @(posedge clk); w++; end while (hreadyout !== 1'h1 && w < 50);
		htrans <= 2'h0;
		hsel <= 1'h0;
		hwdata <= wd;
		do begin @(posedge clk); w++; end while (hreadyout !== 1'h1 && w < 100);
		rd = hrdata;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		bus(1'h0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic drive(input int k, input logic [3:0] l, input logic c);
		irl <= (k == 1) ? l : 4'h0;
		gpio <= (k == 2) ? l : 4'h0;
		calWake <= (k == 3);
		reqWake <= (k == 0);
		calRun <= c;
	endtask
	task automatic enter();
		bus(1'h1, `PDSC_OFF_CTRL, 32'h80);
		haltExec <= 1'h1;
		@(posedge clk);
		haltExec <= 1'h0;
		#1;
		chk({powerState, clockEnable}, 6'h18);
		chk(tsi, 1'h1);
	endtask
	task automatic por();
		reqPor <= 1'h1;
		tick(1);
		reqPor <= 1'h0;
		tick(3);
		chk({powerState.upper, powerState.lower}, 2'h3);
		tick(12);
	endtask
	task automatic hwEnter();
		reqHw <= 1'h1;
		tick(1);
		reqHw <= 1'h0;
		tick(3);
	endtask
	function automatic logic [11:0] evt(input int k, input logic [3:0] l);
		case (k)
			0: return 12'h1c0;
			1: return 12'h200 + {3'h0, ~l, 5'h0};
			2: return 12'h700;
			default: return 12'h480;
		endcase
	endfunction
	logic [7:0] adr [6] = '{`PDSC_OFF_CTRL, `PDSC_OFF_PCTL2, `PDSC_OFF_CLKSTOP,
		`PDSC_OFF_CLKCLR, `PDSC_OFF_SETTLE, 8'h40};
	logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h100, 32'h0};
	initial begin
		void'($urandom(49809));
		tick(8);
		rst <= 1'h0;
		tick(2);
		bus(1'h1, 8'h40, $urandom);
		for (i = 0; i < 6; i++)
			rdchk(adr[i], rv[i]);
		chk(powerState, 3'h1);
		for (i = 0; i < 5; i++) begin
			m = (i == 0) ? 7'h7f : (i == 1) ? 7'h0 : 7'($urandom);
			bus(1'h1, `PDSC_OFF_CTRL, {25'h0, m});
			tick(2);
			chk({25'h0, modEn}, {25'h0, ~m});
		end
		bus(1'h1, `PDSC_OFF_CLKSTOP, 32'h7);
		bus(1'h1, `PDSC_OFF_CLKSTOP, 32'h0);
		tick(2);
		chk({pci, t34, det}, 3'h0);
		bus(1'h1, `PDSC_OFF_CLKCLR, 32'h2);
		tick(2);
		chk({pci, t34, det}, 3'h2);
		rdchk(`PDSC_OFF_CLKCLR, 32'h0);
		bus(1'h1, `PDSC_OFF_CTRL, 32'h55);
		por();
		rdchk(`PDSC_OFF_CTRL, 32'h55);
		rdchk(`PDSC_OFF_CLKSTOP, 32'h5);
		bus(1'h1, `PDSC_OFF_CLKCLR, 32'h7);
		for (s = 0; s < 4; s++) begin
			r = 1 + $urandom % 12;
			mk = 4'($urandom % 14);
			lv = mk + 4'h1 + 4'($urandom % (14 - mk));
			bus(1'h1, `PDSC_OFF_SETTLE, r);
			mask <= mk;
			enter();
			if (s == 1 || s == 2) begin
				drive(s, lv, 1'h0);
				tick(12);
				chk(powerState, 3'h3);
				drive(s, mk, 1'h1);
				tick(12);
				chk(powerState, 3'h3);
			end
			drive(s, lv, 1'h1);
			n = 0;
			do begin tick(1); n++; end while (wakeIrq !== 1'h1 && n < 200);
			if (s != 0)
				chk(32'(n), 32'(r + 2));
			chk({20'h0, eventCode}, {20'h0, evt(s, lv)});
			chk({powerState, clockEnable}, 6'hf);
			drive(4, 4'h0, 1'h0);
		end
		enter();
		reqMr <= 1'h1;
		tick(3);
		chk({powerState.upper, powerState.lower, clockEnable.busOut}, 3'h7);
		reqMr <= 1'h0;
		tick(3);
		chk(powerState, 3'h1);
		enter();
		hwEnter();
		chk({pinsOe, powerState.upper, powerState.lower}, 3'h5);
		por();
		chk(powerState, 3'h1);
		bus(1'h1, `PDSC_OFF_PCTL2, 32'h1);
		hwEnter();
		chk({pinsOe, pullUpEn, powerState, clockEnable, modEn}, 15'h0802);
		mask <= 4'h0;
		drive(1, 4'hf, 1'h1);
		reqMr <= 1'h1;
		tick(20);
		chk({pinsOe, pullUpEn, powerState, clockEnable, modEn}, 15'h0802);
		drive(4, 4'h0, 1'h0);
		reqMr <= 1'h0;
		por();
		chk({pinsOe, powerState}, 4'h9);
		// Hardware standby pin falls while the settle timer counts
		bus(1'h1, `PDSC_OFF_SETTLE, 32'h20);
		enter();
		drive(3, 4'h0, 1'h1);
		tick(3);
		reqHw <= 1'h1;
		tick(2);
		chk({clockEnable, powerState}, 6'h39);
		reqHw <= 1'h0;
		tick(2);
		chk({pinsOe, powerState, clockEnable}, 7'h10);
		drive(4, 4'h0, 1'h0);
		por();
		chk(powerState, 3'h1);
		print_verdict();
	end
endmodule
